// [agd_bank.sv]
// AGC applied gain, noise gate debounce and ADC flag register bank
`timescale 1ns/1ps
module agd_bank #(
	parameter int SAMPLES_PER_TICK = agd_pkg::SAMPLES_PER_TICK
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Audio sample strobe from the converter clocking
	input wire logic sample_stb,
	// AGC engine state, left
	input wire logic [7:0] left_applied_gain,
	input wire logic [6:0] left_pga_applied,
	input wire logic [6:0] left_pga_programmed,
	input wire logic left_adc_powered,
	input wire logic [7:0] left_signal_atten_db,
	// AGC engine state, right
	input wire logic [7:0] right_applied_gain,
	input wire logic [6:0] right_pga_applied,
	input wire logic [6:0] right_pga_programmed,
	input wire logic right_adc_powered,
	input wire logic [7:0] right_signal_atten_db,
	// Settings and noise detection towards the AGC engine
	output logic double_rate_mode,
	output logic [6:0] left_max_gain,
	output logic [6:0] right_max_gain,
	output logic [4:0] left_noise_thr,
	output logic [4:0] right_noise_thr,
	output logic left_noise_detect,
	output logic right_noise_detect,
	// Interrupt
	output logic irq
);
	localparam logic [1:0] TRANS_NONSEQ = 2'b10;
	localparam logic [2:0] SIZE_WORD = 3'b010;

	if (SAMPLES_PER_TICK < 1) begin : g_chk
		$error("agd_bank: SAMPLES_PER_TICK must be at least one");
	end

	// Register state
	logic [7:0] left_gain_ff;
	logic [7:0] right_gain_ff;
	logic [7:0] left_deb_ff;
	logic [7:0] right_deb_ff;
	logic [7:0] flags_ff;
	logic [7:0] nxt_flags;
	logic [6:0] left_max_ff;
	logic [6:0] right_max_ff;
	logic [4:0] left_thr_ff;
	logic [4:0] right_thr_ff;
	logic drm_ff;
	logic [7:0] irq_stat_ff;
	logic [7:0] irq_mask_ff;
	logic irq_ff;

	// Bus state
	logic wr_pend_ff;
	logic [7:0] wr_idx_ff;
	logic [31:0] rdata_ff;
	logic ready_ff;
	logic addr_ok;
	logic [7:0] acc_idx;
	logic [31:0] rd_mux;

	// Debounce support
	logic tick;
	logic [agd_pkg::DEB_CNT_W-1:0] left_noise_ticks;
	logic [agd_pkg::DEB_CNT_W-1:0] left_sig_ticks;
	logic [agd_pkg::DEB_CNT_W-1:0] right_noise_ticks;
	logic [agd_pkg::DEB_CNT_W-1:0] right_sig_ticks;
	logic left_below_raw;
	logic right_below_raw;
	logic left_below;
	logic right_below;
	logic left_thr_on;
	logic right_thr_on;

	// Noise debounce code to half-ms ticks
	function automatic logic [agd_pkg::DEB_CNT_W-1:0] noise_to_ticks(
		input logic [4:0] code
	);
		logic [agd_pkg::DEB_CNT_W-1:0] res;
		res = '0;
		if (code == 5'h00) begin
			res = '0;
		end else if (code < 5'h08) begin
			res = agd_pkg::DEB_CNT_W'(1) << (code - 5'h01);
		end else begin
			// 64 ms per step above code seven
			res = agd_pkg::DEB_CNT_W'(agd_pkg::LONG_STEP_TICKS *
				agd_pkg::DEB_CNT_W'(code - 5'h07));
		end
		return res;
	endfunction : noise_to_ticks

	// Signal debounce code to half-ms ticks
	function automatic logic [agd_pkg::DEB_CNT_W-1:0] sig_to_ticks(
		input logic [2:0] code
	);
		logic [agd_pkg::DEB_CNT_W-1:0] res;
		res = '0;
		if (code != 3'h0) begin
			res = agd_pkg::DEB_CNT_W'(1) << (code - 3'h1);
		end
		return res;
	endfunction : sig_to_ticks

	// Clamp a max gain code to 59.5 dB
	function automatic logic [6:0] clamp_max(input logic [6:0] code);
		return (code > agd_pkg::MAX_GAIN_TOP) ? agd_pkg::MAX_GAIN_TOP : code;
	endfunction : clamp_max

	// Threshold code to attenuation in dB; code 1 is 30 dB down
	function automatic logic [7:0] thr_db(input logic [4:0] code);
		return agd_pkg::THR_BASE_DB + {2'b00, code, 1'b0};
	endfunction : thr_db

	// Half-millisecond tick from the sample strobe
	agd_tick #(
		.SAMPLES(SAMPLES_PER_TICK)
	) u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.sample_stb(sample_stb),
		.tick_ff(tick)
	);

	// Debounce durations for each channel
	assign left_noise_ticks =
		noise_to_ticks(left_deb_ff[agd_pkg::DEB_NOISE_LSB +: 5]);
	assign right_noise_ticks =
		noise_to_ticks(right_deb_ff[agd_pkg::DEB_NOISE_LSB +: 5]);
	assign left_sig_ticks = sig_to_ticks(left_deb_ff[agd_pkg::DEB_SIG_LSB +: 3]);
	assign right_sig_ticks =
		sig_to_ticks(right_deb_ff[agd_pkg::DEB_SIG_LSB +: 3]);

	// Raw noise decision against the threshold
	assign left_thr_on = (left_thr_ff != 5'h00);
	assign right_thr_on = (right_thr_ff != 5'h00);
	assign left_below_raw = left_signal_atten_db > thr_db(left_thr_ff);
	assign right_below_raw = right_signal_atten_db > thr_db(right_thr_ff);

	// Left channel debounce
	agd_debounce u_deb_left (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(tick),
		.noise_ticks(left_noise_ticks),
		.sig_ticks(left_sig_ticks),
		.enable(left_thr_on),
		.below_raw(left_below_raw),
		.below_ff(left_below)
	);

	// Right channel debounce
	agd_debounce u_deb_right (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(tick),
		.noise_ticks(right_noise_ticks),
		.sig_ticks(right_sig_ticks),
		.enable(right_thr_on),
		.below_raw(right_below_raw),
		.below_ff(right_below)
	);

	// Applied gain readback
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			left_gain_ff <= 8'h00;
			right_gain_ff <= 8'h00;
		end else begin
			left_gain_ff <= left_applied_gain;
			right_gain_ff <= right_applied_gain;
		end
	end

	// Next flag value from the engine state
	always_comb begin
		nxt_flags = agd_pkg::RST_FLAGS;
		nxt_flags[agd_pkg::FLG_L_PGA] =
			(left_pga_applied == left_pga_programmed);
		nxt_flags[agd_pkg::FLG_R_PGA] =
			(right_pga_applied == right_pga_programmed);
		nxt_flags[agd_pkg::FLG_L_PWR] = left_adc_powered;
		nxt_flags[agd_pkg::FLG_R_PWR] = right_adc_powered;
		nxt_flags[agd_pkg::FLG_L_NOISE] = left_below;
		nxt_flags[agd_pkg::FLG_R_NOISE] = right_below;
		nxt_flags[agd_pkg::FLG_L_SAT] =
			(left_applied_gain == {1'b0, clamp_max(left_max_ff)});
		nxt_flags[agd_pkg::FLG_R_SAT] =
			(right_applied_gain == {1'b0, clamp_max(right_max_ff)});
	end

	// Read-only flag register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_ff <= agd_pkg::RST_FLAGS;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// Address phase decode
	assign acc_idx = haddr[9:2];
	assign addr_ok = hsel && hready && (htrans == TRANS_NONSEQ) &&
		(hsize == SIZE_WORD);

	// Read mux over the index
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (acc_idx)
			agd_pkg::IDX_LEFT_GAIN: rd_mux[7:0] = left_gain_ff;
			agd_pkg::IDX_RIGHT_GAIN: rd_mux[7:0] = right_gain_ff;
			agd_pkg::IDX_LEFT_DEB: rd_mux[7:0] = left_deb_ff;
			agd_pkg::IDX_RIGHT_DEB: rd_mux[7:0] = right_deb_ff;
			agd_pkg::IDX_FLAGS: rd_mux[7:0] = flags_ff;
			agd_pkg::IDX_LEFT_LIMITS: begin
				rd_mux[agd_pkg::LIM_MAX_LSB +: 7] = left_max_ff;
				rd_mux[agd_pkg::LIM_THR_LSB +: 5] = left_thr_ff;
			end
			agd_pkg::IDX_RIGHT_LIMITS: begin
				rd_mux[agd_pkg::LIM_MAX_LSB +: 7] = right_max_ff;
				rd_mux[agd_pkg::LIM_THR_LSB +: 5] = right_thr_ff;
			end
			agd_pkg::IDX_MODE: rd_mux[0] = drm_ff;
			agd_pkg::IDX_IRQ_STATUS: rd_mux[7:0] = irq_stat_ff;
			agd_pkg::IDX_IRQ_MASK: rd_mux[7:0] = irq_mask_ff;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus handshake: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_ff <= 1'b1;
			hresp <= 1'b0;
		end else begin
			ready_ff <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Capture write address and read data in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= 8'h00;
			rdata_ff <= 32'h0000_0000;
		end else begin
			wr_pend_ff <= addr_ok && hwrite;
			if (addr_ok) begin
				wr_idx_ff <= acc_idx;
			end
			if (addr_ok && !hwrite) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	// Writable debounce settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			left_deb_ff <= agd_pkg::RST_DEB;
			right_deb_ff <= agd_pkg::RST_DEB;
		end else if (wr_pend_ff) begin
			if (wr_idx_ff == agd_pkg::IDX_LEFT_DEB) begin
				left_deb_ff <= hwdata[7:0];
			end
			if (wr_idx_ff == agd_pkg::IDX_RIGHT_DEB) begin
				right_deb_ff <= hwdata[7:0];
			end
		end
	end

	// Maximum gain and noise threshold settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			left_max_ff <= agd_pkg::RST_MAX_GAIN;
			right_max_ff <= agd_pkg::RST_MAX_GAIN;
			left_thr_ff <= agd_pkg::RST_NOISE_THR;
			right_thr_ff <= agd_pkg::RST_NOISE_THR;
		end else if (wr_pend_ff) begin
			if (wr_idx_ff == agd_pkg::IDX_LEFT_LIMITS) begin
				left_max_ff <= hwdata[agd_pkg::LIM_MAX_LSB +: 7];
				left_thr_ff <= hwdata[agd_pkg::LIM_THR_LSB +: 5];
			end
			if (wr_idx_ff == agd_pkg::IDX_RIGHT_LIMITS) begin
				right_max_ff <= hwdata[agd_pkg::LIM_MAX_LSB +: 7];
				right_thr_ff <= hwdata[agd_pkg::LIM_THR_LSB +: 5];
			end
		end
	end

	// Double rate mode; the tick follows the faster sample strobe
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drm_ff <= 1'b0;
		end else if (wr_pend_ff && wr_idx_ff == agd_pkg::IDX_MODE) begin
			drm_ff <= hwdata[0];
		end
	end

	// Interrupt mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_ff <= 8'h00;
		end else if (wr_pend_ff && wr_idx_ff == agd_pkg::IDX_IRQ_MASK) begin
			irq_mask_ff <= hwdata[7:0];
		end
	end

	// Sticky status: rising flag sets, write one clears, set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_ff <= 8'h00;
		end else begin
			if (wr_pend_ff && wr_idx_ff == agd_pkg::IDX_IRQ_STATUS) begin
				irq_stat_ff <= (irq_stat_ff & ~hwdata[7:0]) |
					(nxt_flags & ~flags_ff);
			end else begin
				irq_stat_ff <= irq_stat_ff | (nxt_flags & ~flags_ff);
			end
		end
	end

	// Level interrupt from unmasked status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	// Outputs straight from registers
	assign hrdata = rdata_ff;
	assign hreadyout = ready_ff;
	assign irq = irq_ff;
	assign double_rate_mode = drm_ff;
	assign left_max_gain = left_max_ff;
	assign right_max_gain = right_max_ff;
	assign left_noise_thr = left_thr_ff;
	assign right_noise_thr = right_thr_ff;
	assign left_noise_detect = flags_ff[agd_pkg::FLG_L_NOISE];
	assign right_noise_detect = flags_ff[agd_pkg::FLG_R_NOISE];
endmodule : agd_bank

// [agd_pkg.sv]
// Constants, register map and field layout of the AGC gain/debounce/status bank
//
// Summary of operation
// - Left applied AGC gain reads back as an 8-bit two's-complement value in half-dB steps from -12 to +59.5 dB, zero after reset.
// - Right applied AGC gain reads back the same way in its own read-only register, zero after reset.
// - Left noise debounce code in bits 7..3 gives 0, 0.5, 1, 2, 4, 8, 16, 32 ms for codes 0..7 and 64 ms times (code - 7) above.
// - Right noise debounce code has its own bits 7..3, decoded like the left one, zero after reset.
// - Left signal debounce code in bits 2..0 gives 0, 0.5, 1, 2, 4, 8, 16 or 32 ms, zero after reset.
// - Right signal debounce code has its own bits 2..0 with the same eight steps.
// - Debounce times hold at normal sample rate only and change when double rate mode is on.
// - Flag bits 7 (left) and 3 (right) are one only while applied PGA gain equals programmed PGA gain.
// - Flag bit 6 is one while the left ADC is powered up.
// - Flag bit 2 is one while the right ADC is powered up.
// - Flag bits 5 (left) and 1 (right) are one while signal power is below the noise threshold.
// - Flag bit 4 is one while left applied gain equals the left maximum allowed gain.
// - Flag bit 0 is one while right applied gain equals the right maximum; all flags are read-only and zero after reset.
// - Each channel has a 7-bit maximum gain in half-dB steps, codes above 59.5 dB clamped, used by the saturation flag.
// - Each channel has a 5-bit noise threshold, zero disables detection, other codes give -30 to -90 dB in 2 dB steps.
package agd_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_LEFT_GAIN = 8'h20;
	localparam logic [7:0] IDX_RIGHT_GAIN = 8'h21;
	localparam logic [7:0] IDX_LEFT_DEB = 8'h22;
	localparam logic [7:0] IDX_RIGHT_DEB = 8'h23;
	localparam logic [7:0] IDX_FLAGS = 8'h24;
	localparam logic [7:0] IDX_LEFT_LIMITS = 8'h28;
	localparam logic [7:0] IDX_RIGHT_LIMITS = 8'h29;
	localparam logic [7:0] IDX_MODE = 8'h2A;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h2B;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h2C;
	// Reset values
	localparam logic [7:0] RST_DEB = 8'h00;
	localparam logic [6:0] RST_MAX_GAIN = 7'h7F;
	localparam logic [4:0] RST_NOISE_THR = 5'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	// Limits register field positions
	localparam int LIM_MAX_LSB = 0;
	localparam int LIM_THR_LSB = 8;
	// Debounce field positions
	localparam int DEB_NOISE_LSB = 3;
	localparam int DEB_SIG_LSB = 0;
	// Flag bit positions
	localparam int FLG_L_PGA = 7;
	localparam int FLG_L_PWR = 6;
	localparam int FLG_L_NOISE = 5;
	localparam int FLG_L_SAT = 4;
	localparam int FLG_R_PGA = 3;
	localparam int FLG_R_PWR = 2;
	localparam int FLG_R_NOISE = 1;
	localparam int FLG_R_SAT = 0;
	// Gain and threshold figures in half-dB / dB
	localparam logic [6:0] MAX_GAIN_TOP = 7'h77;
	localparam logic [7:0] THR_BASE_DB = 8'h1C;
	// Debounce step in microseconds and the tick that carries it
	localparam int DEB_STEP_US = 500;
	localparam int SAMPLE_RATE_HZ = 48000;
	localparam int SAMPLES_PER_TICK = SAMPLE_RATE_HZ * DEB_STEP_US / 1000000;
	localparam int DEB_CNT_W = 13;
	localparam logic [DEB_CNT_W-1:0] LONG_STEP_TICKS = 13'h0080;
endpackage : agd_pkg

// [agd_tick.sv]
// Half-millisecond tick divider driven by the audio sample strobe
`timescale 1ns/1ps
module agd_tick #(
	parameter int SAMPLES = agd_pkg::SAMPLES_PER_TICK
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Sample strobe in, tick out
	input wire logic sample_stb,
	output logic tick_ff
);
	localparam int CW = (SAMPLES > 1) ? $clog2(SAMPLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(SAMPLES - 1);

	logic [CW-1:0] cnt_ff;

	if (SAMPLES < 1) begin : g_chk
		$error("agd_tick: SAMPLES must be at least one");
	end

	// Count samples; a doubled sample rate halves the tick period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= 1'b0;
			if (sample_stb) begin
				if (cnt_ff == LAST) begin
					cnt_ff <= '0;
					tick_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 1'b1;
				end
			end
		end
	end
endmodule : agd_tick

// [agd_debounce.sv]
// Noise/signal debounce of one channel's below-threshold decision
`timescale 1ns/1ps
module agd_debounce (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Timing
	input wire logic tick,
	input wire logic [agd_pkg::DEB_CNT_W-1:0] noise_ticks,
	input wire logic [agd_pkg::DEB_CNT_W-1:0] sig_ticks,
	// Decision
	input wire logic enable,
	input wire logic below_raw,
	output logic below_ff
);
	logic [agd_pkg::DEB_CNT_W-1:0] cnt_ff;
	logic [agd_pkg::DEB_CNT_W-1:0] target;

	// Time to hold the new state before it is taken
	assign target = below_raw ? noise_ticks : sig_ticks;

	// Flip only after the raw state persists for the target time; a disabled channel clears at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= '0;
			below_ff <= 1'b0;
		end else if (!enable) begin
			cnt_ff <= '0;
			below_ff <= 1'b0;
		end else if (below_raw == below_ff) begin
			cnt_ff <= '0;
		end else if (cnt_ff >= target) begin
			cnt_ff <= '0;
			below_ff <= below_raw;
		end else if (tick) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end
endmodule : agd_debounce

// [agd_bank_checker.sv]
// Port assertions of the AGC gain, debounce and flag register bank
`timescale 1ns/1ps
module agd_bank_checker (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus address phase and read data
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Engine state
	input wire logic [7:0] left_applied_gain,
	input wire logic [7:0] right_applied_gain,
	input wire logic [6:0] left_pga_applied,
	input wire logic [6:0] left_pga_programmed,
	input wire logic [6:0] right_pga_applied,
	input wire logic [6:0] right_pga_programmed,
	input wire logic left_adc_powered,
	input wire logic right_adc_powered,
	// Settings and detection
	input wire logic [6:0] left_max_gain,
	input wire logic [6:0] right_max_gain,
	input wire logic [4:0] left_noise_thr,
	input wire logic [4:0] right_noise_thr,
	input wire logic left_noise_detect,
	input wire logic right_noise_detect
);
	logic rd_go;
	logic [7:0] rd_idx;
	logic [7:0] l_cap;
	logic [7:0] r_cap;
	// Accepted read address phase and clamped gain ceilings
	assign rd_go = hsel && hready && htrans == 2'h2 && !hwrite && hsize == 3'h2;
	assign rd_idx = haddr[9:2];
	assign l_cap = {1'b0, (left_max_gain > 7'h77) ? 7'h77 : left_max_gain};
	assign r_cap = {1'b0, (right_max_gain > 7'h77) ? 7'h77 : right_max_gain};
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_left_gain: assert property (
		rd_go && rd_idx == 8'h20 && $stable(left_applied_gain)
		|=> hrdata == {24'h0, $past(left_applied_gain)})
		else $error("left gain readback differs from engine gain");
	a_right_gain: assert property (
		rd_go && rd_idx == 8'h21 && $stable(right_applied_gain)
		|=> hrdata == {24'h0, $past(right_applied_gain)})
		else $error("right gain readback differs from engine gain");
	a_left_pga_power: assert property (
		rd_go && rd_idx == 8'h24 && $stable(left_pga_applied)
		&& $stable(left_pga_programmed) && $stable(left_adc_powered)
		|=> hrdata[7] == ($past(left_pga_applied) == $past(left_pga_programmed))
		&& hrdata[6] == $past(left_adc_powered))
		else $error("left pga or power flag wrong");
	a_right_pga_power: assert property (
		rd_go && rd_idx == 8'h24 && $stable(right_pga_applied)
		&& $stable(right_pga_programmed) && $stable(right_adc_powered)
		|=> hrdata[3] == ($past(right_pga_applied) == $past(right_pga_programmed))
		&& hrdata[2] == $past(right_adc_powered))
		else $error("right pga or power flag wrong");
	a_left_sat_flag: assert property (
		rd_go && rd_idx == 8'h24 && $stable(left_applied_gain) && $stable(l_cap)
		|=> hrdata[4] == ($past(left_applied_gain) == $past(l_cap)))
		else $error("left saturation flag wrong");
	a_right_sat_flag: assert property (
		rd_go && rd_idx == 8'h24 && $stable(right_applied_gain)
		&& $stable(r_cap)
		|=> hrdata[0] == ($past(right_applied_gain) == $past(r_cap)))
		else $error("right saturation flag wrong");
	a_noise_flag_copy: assert property (
		rd_go && rd_idx == 8'h24 && $stable(left_noise_detect)
		&& $stable(right_noise_detect) |=> hrdata[5] == $past(left_noise_detect)
		&& hrdata[1] == $past(right_noise_detect))
		else $error("noise flags differ from detect outputs");
	a_noise_off_left: assert property (
		(left_noise_thr == 5'h0) [*3] |-> !left_noise_detect)
		else $error("left noise detect with detection off");
	a_noise_off_right: assert property (
		(right_noise_thr == 5'h0) [*3] |-> !right_noise_detect)
		else $error("right noise detect with detection off");
endmodule : agd_bank_checker

bind agd_bank agd_bank_checker u_chk (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hsize, .hready, .hrdata, .left_applied_gain,
	.right_applied_gain, .left_pga_applied, .left_pga_programmed,
	.right_pga_applied, .right_pga_programmed, .left_adc_powered,
	.right_adc_powered, .left_max_gain, .right_max_gain, .left_noise_thr,
	.right_noise_thr, .left_noise_detect, .right_noise_detect);

// [agd_bank_test.sv]
// Self-checking bench of the AGC gain, debounce and flag register bank
`timescale 1ns/1ps
module agd_bank_test;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic sample_stb = 1'b0;
	logic [7:0] left_applied_gain = 8'h0, right_applied_gain = 8'h0;
	logic [6:0] left_pga_applied = 7'h0, left_pga_programmed = 7'h0;
	logic [6:0] right_pga_applied = 7'h0, right_pga_programmed = 7'h0;
	logic left_adc_powered = 1'b0, right_adc_powered = 1'b0;
	logic [7:0] left_signal_atten_db = 8'h0, right_signal_atten_db = 8'h0;
	logic [31:0] hrdata;
	logic hready, hreadyout, hresp, irq, double_rate_mode;
	logic left_noise_detect, right_noise_detect;
	logic [6:0] left_max_gain, right_max_gain;
	logic [4:0] left_noise_thr, right_noise_thr;
	int fails = 0, tests_run = 0, seed = 98, sp = 2, ml = 127, mr = 127, p;
	logic [7:0] stat = 8'h0, of = 8'h0, msk = 8'h0, clr;
	assign hready = hreadyout;

	agd_bank #(.SAMPLES_PER_TICK(1)) dut (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
		.hresp, .sample_stb, .left_applied_gain, .left_pga_applied,
		.left_pga_programmed, .left_adc_powered, .left_signal_atten_db,
		.right_applied_gain, .right_pga_applied, .right_pga_programmed,
		.right_adc_powered, .right_signal_atten_db, .double_rate_mode,
		.left_max_gain, .right_max_gain, .left_noise_thr, .right_noise_thr,
		.left_noise_detect, .right_noise_detect, .irq);

	// Clock and sample strobe, one strobe every sp cycles
	always #5 hclk = ~hclk;
	always @(posedge hclk) begin
		sample_stb <= (sp == 1) ? 1'b1 : ~sample_stb;
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Cuts a hung wait short
	task automatic bound(input int n, input int lim);
		if (n > lim) begin
			chk("wait bound", 0, 1);
			stop_test();
		end
	endtask : bound

	task automatic wt_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			n++;
			bound(n, 50);
			@(posedge hclk);
		end
	endtask : wt_rdy

	// One single word transfer, address then data phase
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [31:0] wd, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		wt_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wt_rdy();
		d = hrdata;
		chk("response", 1'b0, hresp);
	endtask : xfer

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		xfer(1'b1, idx, wd, d);
	endtask : wr

	task automatic rc(input string nm, input logic [7:0] idx,
		input logic [31:0] e);
		logic [31:0] d;
		xfer(1'b0, idx, 32'h0, d);
		chk(nm, e, d);
	endtask : rc

	// Flag register model from the current engine inputs
	function automatic logic [7:0] flg_m();
		logic [7:0] f;
		f = 8'h0;
		f[7] = left_pga_applied == left_pga_programmed;
		f[6] = left_adc_powered;
		f[4] = left_applied_gain == (ml > 'h77 ? 'h77 : ml);
		f[3] = right_pga_applied == right_pga_programmed;
		f[2] = right_adc_powered;
		f[0] = right_applied_gain == (mr > 'h77 ? 'h77 : mr);
		return f;
	endfunction : flg_m

	// Sticky status gains every rising flag
	task automatic upd();
		logic [7:0] nf;
		nf = flg_m();
		stat = stat | (nf & ~of);
		of = nf;
	endtask : upd

	function automatic logic [7:0] gain_r(input int m, input bit sat);
		int g;
		g = (($random(seed) & 'hFF) % 144) - 24;
		if (sat)
			g = (m > 'h77) ? 'h77 : m;
		return 8'(g);
	endfunction : gain_r

	function automatic int ticks(input int c);
		return (c == 0) ? 0 : (c < 8) ? 1 << (c - 1) : 128 * (c - 7);
	endfunction : ticks

	// Debounce timing of one channel, threshold code 5 is 38 dB
	task automatic deb_t(input int ch, input int nc, input int sc, input int s);
		int n;
		int t;
		logic [31:0] d;
		sp = s;
		wr(agd_pkg::IDX_MODE, 32'(s == 1));
		wr(8'(agd_pkg::IDX_LEFT_LIMITS + ch), 32'h577);
		wr(8'(agd_pkg::IDX_LEFT_DEB + ch), 32'((nc << 3) | sc));
		chk("double rate", 32'(s == 1), double_rate_mode);
		chk("thr", 5, ch ? right_noise_thr : left_noise_thr);
		for (int k = 39; k >= 38; k--) begin
			if (ch)
				right_signal_atten_db <= 8'(k);
			else
				left_signal_atten_db <= 8'(k);
			t = ticks(k == 39 ? nc : sc) * s;
			n = 0;
			while ((ch ? right_noise_detect : left_noise_detect) !== (k == 39)) begin
				@(posedge hclk);
				n++;
				bound(n, 8000);
			end
			chk("debounce", 1, 32'(n >= t - s && n <= t + s + 6));
			xfer(1'b0, agd_pkg::IDX_FLAGS, 32'h0, d);
			chk("noise flag", 32'(k == 39), 32'(d[ch ? 1 : 5]));
		end
	endtask : deb_t

	// Main sequence
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		upd();
		rc("left gain", agd_pkg::IDX_LEFT_GAIN, 0);
		rc("right gain", agd_pkg::IDX_RIGHT_GAIN, 0);
		// Byte sized write is not served
		hsize <= 3'h0;
		wr(agd_pkg::IDX_LEFT_DEB, 32'hFF);
		hsize <= 3'h2;
		rc("left deb", agd_pkg::IDX_LEFT_DEB, 0);
		rc("right deb", agd_pkg::IDX_RIGHT_DEB, 0);
		rc("limits", agd_pkg::IDX_RIGHT_LIMITS, 32'h7F);
		wr(agd_pkg::IDX_LEFT_GAIN, 32'hFF);
		wr(agd_pkg::IDX_FLAGS, 32'hFF);
		wr(8'h25, 32'hFF);
		rc("left gain ro", agd_pkg::IDX_LEFT_GAIN, 0);
		rc("flags ro", agd_pkg::IDX_FLAGS, of);
		rc("unmapped", 8'h25, 0);
		rc("status", agd_pkg::IDX_IRQ_STATUS, stat);
		// Random engine states, gain ceilings, masks and clears
		for (int i = 0; i < 24; i++) begin
			ml = $random(seed) & 'h7F;
			mr = (i % 4 == 0) ? 'h7F : $random(seed) & 'h7F;
			wr(agd_pkg::IDX_LEFT_LIMITS, ml);
			wr(agd_pkg::IDX_RIGHT_LIMITS, mr);
			repeat (2) @(posedge hclk);
			upd();
			p = $random(seed);
			left_applied_gain <= gain_r(ml, i % 3 == 0);
			right_applied_gain <= gain_r(mr, i % 3 == 1);
			left_pga_applied <= 7'(p);
			left_pga_programmed <= i[0] ? 7'(p) : 7'(p >> 8);
			right_pga_applied <= 7'(p);
			right_pga_programmed <= i[0] ? 7'(p >> 8) : 7'(p);
			left_adc_powered <= p[16];
			right_adc_powered <= p[17];
			repeat (3) @(posedge hclk);
			upd();
			msk = 8'($random(seed));
			clr = 8'($random(seed));
			wr(agd_pkg::IDX_IRQ_MASK, msk);
			rc("status", agd_pkg::IDX_IRQ_STATUS, stat);
			wr(agd_pkg::IDX_IRQ_STATUS, clr);
			stat = stat & ~clr;
			rc("left gain", agd_pkg::IDX_LEFT_GAIN, left_applied_gain);
			rc("right gain", agd_pkg::IDX_RIGHT_GAIN, right_applied_gain);
			rc("flags", agd_pkg::IDX_FLAGS, of);
			rc("mask", agd_pkg::IDX_IRQ_MASK, msk);
			rc("status", agd_pkg::IDX_IRQ_STATUS, stat);
			chk("irq", |(stat & msk), irq);
			chk("left max", ml, left_max_gain);
			chk("right max", mr, right_max_gain);
		end
		// Every noise debounce code, random signal codes
		for (int c = 0; c < 32; c++) begin
			p = $random(seed) & 7;
			wr(agd_pkg::IDX_LEFT_DEB, 32'hFFFFFF00 | (c << 3) | p);
			wr(agd_pkg::IDX_RIGHT_DEB, ((31 - c) << 3) | (7 - p));
			rc("left deb", agd_pkg::IDX_LEFT_DEB, (c << 3) | p);
			rc("right deb", agd_pkg::IDX_RIGHT_DEB, ((31 - c) << 3) | (7 - p));
		end
		deb_t(0, 3, 2, 2);
		deb_t(1, 31, 1, 2);
		deb_t(0, 8, 7, 1);
		deb_t(1, 0, 0, 1);
		// Detection switched off while the left flag is up
		left_signal_atten_db <= 8'hFF;
		repeat (150) @(posedge hclk);
		chk("noise on", 1, left_noise_detect);
		wr(agd_pkg::IDX_LEFT_LIMITS, 32'h77);
		repeat (3) @(posedge hclk);
		chk("noise off", 0, left_noise_detect);
		stop_test();
	end
endmodule : agd_bank_test
